// *** core/wds_pkg.sv ***
// constants shared by the watchdog and sleep control block
package wds_pkg;
	// system clock and the low-frequency time base
	localparam int CLK_HZ = 250_000_000;
	localparam int LF_HZ = 31_000;
	localparam int LF_DIV_CYC = CLK_HZ / LF_HZ;

	// register offsets on the software port
	localparam logic [8:0] OFF_STATUS = 9'h003;
	localparam logic [8:0] OFF_OPTION = 9'h081;
	localparam logic [8:0] OFF_CTRL = 9'h105;
	localparam logic [8:0] OFF_CONFIG = 9'h107;

	// reset values
	localparam logic [7:0] CTRL_RST = 8'h08;
	localparam logic [7:0] OPTION_RST = 8'hFF;
	localparam logic TO_RST = 1'b1;
	localparam logic PD_RST = 1'b1;

	// field positions
	localparam int CTRL_SWEN_BIT = 0;
	localparam int CTRL_PS_LSB = 1;
	localparam int CTRL_PS_W = 4;
	localparam int CTRL_W = 5;
	localparam int STATUS_TO_BIT = 4;
	localparam int STATUS_PD_BIT = 3;
	localparam int CFG_CONFIG_WATCHDOG_ENABLE_BIT = 3;

	// period select decode: ratio = 2^(PS_BASE_SHIFT + code)
	localparam logic [3:0] PS_MAX = 4'hB;
	localparam int PS_BASE_SHIFT = 5;
	localparam int PRE_W = 16;

	typedef enum logic [1:0] {
		WDS_AWAKE,
		WDS_ASLEEP,
		WDS_WAKE_OST
	} wds_state_t;
endpackage : wds_pkg

// *** core/wds_tick_div.sv ***
// divider making the one-cycle low-frequency oscillator tick
`timescale 1ns/1ps
module wds_tick_div #(
	parameter int DIV = wds_pkg::LF_DIV_CYC
) (
	input wire logic clk,
	input wire logic reset,
	output logic tick
);
	localparam int CW = $clog2(DIV);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic tick_q;
	logic tick_d;

	always_comb begin
		tick_d = (cnt_q == LAST);
		cnt_d = tick_d ? '0 : cnt_q + CW'(1);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;
endmodule : wds_tick_div

// *** core/wds_prescaler.sv ***
// programmable 16-bit watchdog prescaler with period expiry pulse
`timescale 1ns/1ps
module wds_prescaler #(
	parameter int W = wds_pkg::PRE_W
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic tick,
	input wire logic clear,
	input wire logic [3:0] sel,
	output logic [W-1:0] count,
	output logic expire
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic exp_q;
	logic exp_d;
	logic [3:0] code;
	logic [W:0] ratio;
	logic [W-1:0] limit;

	always_comb begin
		// reserved codes behave as the longest period
		code = (sel > wds_pkg::PS_MAX) ? wds_pkg::PS_MAX : sel;
		ratio = (W+1)'(1) << (wds_pkg::PS_BASE_SHIFT + int'(code));
		limit = W'(ratio - (W+1)'(1));
		exp_d = 1'b0;
		cnt_d = cnt_q;
		if (clear) begin
			cnt_d = '0;
		end else if (tick) begin
			if (cnt_q >= limit) begin
				cnt_d = '0;
				exp_d = 1'b1;
			end else begin
				cnt_d = cnt_q + W'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_q <= '0;
			exp_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			exp_q <= exp_d;
		end
	end

	assign count = cnt_q;
	assign expire = exp_q;
endmodule : wds_prescaler

// *** core/wds_top.sv ***
// watchdog timer with sleep entry, wake-up and status flags
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module wds_top #(
	parameter int LF_DIV = wds_pkg::LF_DIV_CYC
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [8:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata,
	input wire logic [7:0] config_word,
	input wire logic crystal_clock_mode,
	input wire logic sleep_instr,
	input wire logic clear_watchdog_instr,
	input wire logic osc_fail,
	input wire logic wake_pending,
	input wire logic ost_active,
	input wire logic ost_done,
	input wire logic timer1_osc_req,
	output logic wdt_reset,
	output logic wake_resume,
	output logic ost_start,
	output logic sleeping,
	output logic osc_driver_en,
	output logic io_hold,
	output logic timer1_osc_en,
	output logic power_down_flag,
	output logic timeout_flag,
	output logic master_clear_pin_o,
	output logic master_clear_pin_oe
);
	localparam int PSL = wds_pkg::CTRL_PS_LSB;
	localparam int PSH = wds_pkg::CTRL_PS_LSB + wds_pkg::CTRL_PS_W - 1;
	localparam int CW = wds_pkg::CTRL_W;

	wds_pkg::wds_state_t state_q;
	wds_pkg::wds_state_t state_d;
	logic pd_q;
	logic pd_d;
	logic to_q;
	logic to_d;
	logic rst_q;
	logic rst_d;
	logic wake_q;
	logic wake_d;
	logic ost_q;
	logic ost_d;
	logic t1_q;
	logic t1_d;
	logic [CW-1:0] ctrl_q;
	logic [CW-1:0] ctrl_d;
	logic [7:0] opt_q;
	logic [7:0] opt_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;

	logic lf_tick;
	logic wdt_expire;
	logic [wds_pkg::PRE_W-1:0] pre_count;
	logic cfg_config_watchdog_enable;
	logic soft_en;
	logic wdt_run;
	logic sleep_take;
	logic sleep_exit;
	logic wdt_clear;

	assign cfg_config_watchdog_enable = config_word[wds_pkg::CFG_CONFIG_WATCHDOG_ENABLE_BIT];
	assign soft_en = ctrl_q[wds_pkg::CTRL_SWEN_BIT];
	assign wdt_run = cfg_config_watchdog_enable | soft_en;

	// a pending wake source turns the sleep instruction into a no-op
	assign sleep_take = sleep_instr && (state_q == wds_pkg::WDS_AWAKE)
		&& !wake_pending;
	assign sleep_exit = (state_q == wds_pkg::WDS_ASLEEP) && (wdt_expire || wake_pending);

	// start-up timer borrows the ripple counter, so it stays clear meanwhile
	assign wdt_clear = !wdt_run
		| clear_watchdog_instr
		| osc_fail
		| sleep_take
		| sleep_exit
		| (state_q == wds_pkg::WDS_WAKE_OST)
		| ost_active;

	wds_tick_div #(
		.DIV(LF_DIV)
	) u_tick (
		.clk(clk),
		.reset(reset),
		.tick(lf_tick)
	);

	wds_prescaler #(
		.W(wds_pkg::PRE_W)
	) u_pre (
		.clk(clk),
		.reset(reset),
		.tick(lf_tick),
		.clear(wdt_clear),
		.sel(ctrl_q[PSH:PSL]),
		.count(pre_count),
		.expire(wdt_expire)
	);

	// sleep sequencing and status flags
	always_comb begin
		state_d = state_q;
		pd_d = pd_q;
		to_d = to_q;
		rst_d = 1'b0;
		wake_d = 1'b0;
		ost_d = 1'b0;
		case (state_q)
			wds_pkg::WDS_AWAKE: begin
				if (wdt_expire) begin
					rst_d = 1'b1;
					to_d = 1'b0;
				end else if (sleep_take) begin
					state_d = wds_pkg::WDS_ASLEEP;
					pd_d = 1'b0;
					to_d = 1'b1;
				end
			end
			wds_pkg::WDS_ASLEEP: begin
				if (sleep_exit) begin
					if (wdt_expire) begin
						to_d = 1'b0;
					end
					if (crystal_clock_mode) begin
						state_d = wds_pkg::WDS_WAKE_OST;
						ost_d = 1'b1;
					end else begin
						state_d = wds_pkg::WDS_AWAKE;
						wake_d = 1'b1;
					end
				end
			end
			wds_pkg::WDS_WAKE_OST: begin
				if (ost_done) begin
					state_d = wds_pkg::WDS_AWAKE;
					wake_d = 1'b1;
				end
			end
			default: begin
				state_d = wds_pkg::WDS_AWAKE;
			end
		endcase
		// timer1 oscillator follows its own request in every state
		t1_d = timer1_osc_req;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= wds_pkg::WDS_AWAKE;
			pd_q <= wds_pkg::PD_RST;
			to_q <= wds_pkg::TO_RST;
			rst_q <= 1'b0;
			wake_q <= 1'b0;
			ost_q <= 1'b0;
			t1_q <= 1'b0;
		end else begin
			state_q <= state_d;
			pd_q <= pd_d;
			to_q <= to_d;
			rst_q <= rst_d;
			wake_q <= wake_d;
			ost_q <= ost_d;
			t1_q <= t1_d;
		end
	end

	// register file; the internal watchdog reset reloads it like any reset
	always_comb begin
		ctrl_d = ctrl_q;
		opt_d = opt_q;
		rdata_d = 8'h00;
		if (rst_q) begin
			ctrl_d = wds_pkg::CTRL_RST[CW-1:0];
			opt_d = wds_pkg::OPTION_RST;
		end else if (wr_en) begin
			case (addr)
				wds_pkg::OFF_CTRL: begin
					ctrl_d = wdata[CW-1:0];
				end
				wds_pkg::OFF_OPTION: begin
					opt_d = wdata;
				end
				default: begin
					ctrl_d = ctrl_q;
				end
			endcase
		end
		if (rd_en) begin
			case (addr)
				wds_pkg::OFF_CTRL: begin
					rdata_d = {3'h0, ctrl_q};
				end
				wds_pkg::OFF_OPTION: begin
					rdata_d = opt_q;
				end
				wds_pkg::OFF_CONFIG: begin
					rdata_d = config_word;
				end
				wds_pkg::OFF_STATUS: begin
					rdata_d[wds_pkg::STATUS_TO_BIT] = to_q;
					rdata_d[wds_pkg::STATUS_PD_BIT] = pd_q;
				end
				default: begin
					rdata_d = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_q <= wds_pkg::CTRL_RST[CW-1:0];
			opt_q <= wds_pkg::OPTION_RST;
			rdata_q <= 8'h00;
		end else begin
			ctrl_q <= ctrl_d;
			opt_q <= opt_d;
			rdata_q <= rdata_d;
		end
	end

	assign rdata = rdata_q;
	assign wdt_reset = rst_q;
	assign wake_resume = wake_q;
	assign ost_start = ost_q;
	assign sleeping = (state_q == wds_pkg::WDS_ASLEEP);
	assign osc_driver_en = (state_q != wds_pkg::WDS_ASLEEP);
	assign io_hold = (state_q == wds_pkg::WDS_ASLEEP);
	assign timer1_osc_en = t1_q;
	assign power_down_flag = pd_q;
	assign timeout_flag = to_q;
	// the watchdog reset stays inside the device, the pin is never driven
	assign master_clear_pin_o = 1'b0;
	assign master_clear_pin_oe = 1'b0;

	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);

	a_sleep_flags: assert property (
		sleep_take && !wdt_expire |=> !power_down_flag && timeout_flag && sleeping
	) else $error("sleep entry did not update the status flags");

	a_awake_timeout: assert property (
		wdt_expire && state_q == wds_pkg::WDS_AWAKE |=> wdt_reset && !timeout_flag
	) else $error("awake expiry gave no internal reset");

	a_sleep_wake: assert property (
		wdt_expire && sleeping && !crystal_clock_mode
		|=> wake_resume && !timeout_flag && !sleeping
	) else $error("expiry in sleep did not wake the device");

	a_config_force: assert property (
		cfg_config_watchdog_enable && !ost_active && !sleeping && state_q == wds_pkg::WDS_AWAKE
		&& !clear_watchdog_instr && !osc_fail && !sleep_take
		|-> !wdt_clear
	) else $error("configuration enable did not force the watchdog on");

	a_soft_off: assert property (
		(!cfg_config_watchdog_enable && !soft_en) [*2] |-> !wdt_expire && pre_count == '0
	) else $error("disabled watchdog kept counting");

	a_ost_hold: assert property (
		ost_active |=> pre_count == '0
	) else $error("counter moved while start-up timer ran");

	a_crystal_hold: assert property (
		state_q == wds_pkg::WDS_WAKE_OST |=> pre_count == '0 && !wdt_expire
	) else $error("watchdog not held during crystal start-up");

	a_clear_instr: assert property (
		clear_watchdog_instr || osc_fail |=> pre_count == '0
	) else $error("clear source left the count standing");

	a_ctrl_reload: assert property (
		wdt_reset |=> {3'h0, ctrl_q} == wds_pkg::CTRL_RST
	) else $error("control not reloaded after watchdog reset");

	a_pin_quiet: assert property (
		!master_clear_pin_oe
	) else $error("master clear pin was driven");

	a_osc_off: assert property (
		sleeping |-> !osc_driver_en && io_hold
	) else $error("oscillator driver ran in sleep");

	a_noop_sleep: assert property (
		sleep_instr && wake_pending |=> !sleeping && $stable(power_down_flag)
	) else $error("sleep instruction with a pending wake was not a no-op");

	a_wake_clear: assert property (
		sleep_exit |=> pre_count == '0 && !wdt_expire
	) else $error("sleep exit left the count standing");

	a_sleep_count: assert property (
		sleep_take |=> pre_count == '0 && !wdt_expire
	) else $error("sleep entry did not clear the count");

	a_ctrl_upper: assert property (
		rd_en && addr == wds_pkg::OFF_CTRL |=> rdata[7:5] == 3'h0
	) else $error("control read showed unimplemented bits");

	a_status_read: assert property (
		rd_en && addr == wds_pkg::OFF_STATUS
		|=> rdata[wds_pkg::STATUS_TO_BIT] == $past(timeout_flag)
		&& rdata[wds_pkg::STATUS_PD_BIT] == $past(power_down_flag)
	) else $error("status read did not show the flags");

	a_t1_follow: assert property (
		sleeping |=> timer1_osc_en == $past(timer1_osc_req)
	) else $error("timer1 oscillator changed by sleep");

	a_ost_request: assert property (
		sleep_exit && crystal_clock_mode |=> ost_start && !wake_resume && !sleeping
	) else $error("crystal wake skipped the start-up timer");

	a_awake_drive: assert property (
		!sleeping |-> osc_driver_en && !io_hold
	) else $error("ports held while awake");
endmodule : wds_top

// *** test/test_wds_top.sv ***
// self-checking bench for the watchdog and sleep control block
`timescale 1ns/1ps
module test_wds_top;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [8:0] addr = 9'h000;
	logic [7:0] wdata = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] rdata;
	logic [7:0] config_word = 8'hA5;
	logic crystal_clock_mode = 1'b0;
	logic sleep_instr = 1'b0;
	logic clear_watchdog_instr = 1'b0;
	logic osc_fail = 1'b0;
	logic wake_pending = 1'b0;
	logic ost_active = 1'b0;
	logic ost_done = 1'b0;
	logic timer1_osc_req = 1'b0;
	logic wdt_reset, wake_resume, ost_start, sleeping, osc_driver_en, io_hold;
	logic timer1_osc_en, power_down_flag, timeout_flag, master_clear_pin_o, master_clear_pin_oe;
	int fails = 0;
	int n_tests = 0;
	int n_rst = 0;
	int n;
	int k;
	logic [7:0] d;

	// small divider keeps every watchdog period short: one tick per 4 clocks
	wds_top #(.LF_DIV(4)) u_wds_top (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .config_word(config_word),
		.crystal_clock_mode(crystal_clock_mode), .sleep_instr(sleep_instr),
		.clear_watchdog_instr(clear_watchdog_instr), .osc_fail(osc_fail),
		.wake_pending(wake_pending), .ost_active(ost_active), .ost_done(ost_done),
		.timer1_osc_req(timer1_osc_req), .wdt_reset(wdt_reset), .wake_resume(wake_resume),
		.ost_start(ost_start), .sleeping(sleeping), .osc_driver_en(osc_driver_en),
		.io_hold(io_hold), .timer1_osc_en(timer1_osc_en), .power_down_flag(power_down_flag),
		.timeout_flag(timeout_flag), .master_clear_pin_o(master_clear_pin_o),
		.master_clear_pin_oe(master_clear_pin_oe));

	always #2 clk = ~clk;

	always @(posedge clk) begin
		if (wdt_reset === 1'b1) n_rst++;
	end

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [8:0] a, input logic [7:0] v);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr

	task automatic rd(input logic [8:0] a, output logic [7:0] v);
		@(posedge clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 v = rdata;
	endtask : rd

	// cycles until the chosen pulse; lim + 1 when it never came
	task automatic wait_for(input int sel, input int lim, output int cnt);
		logic hit;
		cnt = 0;
		hit = 1'b0;
		while (cnt < lim && !hit) begin
			@(posedge clk);
			#1 cnt++;
			hit = (sel == 0) ? (wdt_reset === 1'b1) : (sel == 1) ? (wake_resume === 1'b1)
				: (ost_start === 1'b1);
		end
		if (!hit) cnt = lim + 1;
	endtask : wait_for

	// tick phase is unknown, so allow one tick of slack either side
	function automatic logic [7:0] inr(input int c, input int r);
		return (c >= 4 * r - 4 && c <= 4 * r + 4) ? 8'h01 : 8'h00;
	endfunction : inr

	task automatic pulse_sleep();
		@(posedge clk);
		sleep_instr <= 1'b1;
		@(posedge clk);
		sleep_instr <= 1'b0;
		#1;
	endtask : pulse_sleep

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : print_verdict

	initial begin
		#80000;
		fails++;
		print_verdict();
	end

	initial begin
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		rd(wds_pkg::OFF_CTRL, d);
		chk("ctrl reset", d, wds_pkg::CTRL_RST);
		chk("flags reset", {6'h00, timeout_flag, power_down_flag}, 8'h03);
		chk("master_clear_pin", {6'h00, master_clear_pin_o, master_clear_pin_oe}, 8'h00);
		rd(wds_pkg::OFF_OPTION, d);
		chk("option reset", d, wds_pkg::OPTION_RST);
		rd(wds_pkg::OFF_CONFIG, d);
		chk("config", d, 8'hA5);
		wr(wds_pkg::OFF_CTRL, 8'hFE);
		rd(wds_pkg::OFF_CTRL, d);
		chk("ctrl upper bits", d, 8'h1E);
		wr(wds_pkg::OFF_OPTION, 8'h5A);
		wr(9'h1FF, 8'hFF);
		wr(wds_pkg::OFF_STATUS, 8'h00);
		rd(wds_pkg::OFF_OPTION, d);
		chk("option rw", d, 8'h5A);
		rd(9'h1FF, d);
		chk("unmapped", d, 8'h00);
		rd(wds_pkg::OFF_STATUS, d);
		chk("status ro", d & 8'h18, 8'h18);
		$display("test registers done");
		// sleep with an interrupt already pending completes as a no-op
		@(posedge clk);
		wake_pending <= 1'b1;
		pulse_sleep();
		chk("noop sleep", {6'h00, sleeping, power_down_flag}, 8'h01);
		@(posedge clk);
		wake_pending <= 1'b0;
		for (k = 0; k < 3; k++) begin
			wr(wds_pkg::OFF_CTRL, {3'b000, k[3:0], 1'b1});
			wait_for(0, 4 * (32 << k) + 20, n);
			chk("period", inr(n, 32 << k), 8'h01);
		end
		chk("timeout after expiry", {7'h00, timeout_flag}, 8'h00);
		rd(wds_pkg::OFF_CTRL, d);
		chk("ctrl after expiry", d, wds_pkg::CTRL_RST);
		wr(wds_pkg::OFF_CTRL, 8'h00);
		config_word <= 8'h08;
		wait_for(0, 200, n);
		chk("config enable", inr(n, 32), 8'h01);
		$display("test periods done");
		wr(wds_pkg::OFF_CTRL, 8'h01);
		config_word <= 8'hA5;
		k = n_rst;
		// one source at a time: each alone must keep the 128-cycle period from running out
		for (n = 0; n < 16; n++) begin
			repeat (90) @(posedge clk);
			clear_watchdog_instr <= (n < 8);
			osc_fail <= (n >= 8);
			@(posedge clk);
			clear_watchdog_instr <= 1'b0;
			osc_fail <= 1'b0;
		end
		chk("clears hold off", n_rst - k, 8'h00);
		wr(wds_pkg::OFF_CTRL, 8'h00);
		repeat (300) @(posedge clk);
		chk("disabled", n_rst - k, 8'h00);
		wr(wds_pkg::OFF_CTRL, 8'h01);
		ost_active <= 1'b1;
		repeat (400) @(posedge clk);
		chk("start-up hold", n_rst - k, 8'h00);
		ost_active <= 1'b0;
		wait_for(0, 200, n);
		chk("resume after hold", inr(n, 32), 8'h01);
		$display("test clears done");
		wr(wds_pkg::OFF_CTRL, 8'h01);
		timer1_osc_req <= 1'b1;
		// let the count run first, so a sleep entry that fails to clear it expires early
		repeat (60) @(posedge clk);
		pulse_sleep();
		chk("sleep outputs", {4'h0, sleeping, osc_driver_en, io_hold, power_down_flag},
			8'h0A);
		chk("sleep timeout", {6'h00, timeout_flag, timer1_osc_en}, 8'h03);
		wait_for(1, 200, n);
		chk("sleep expiry", inr(n, 32), 8'h01);
		chk("wake flags", {4'h0, sleeping, timeout_flag, osc_driver_en, io_hold},
			8'h02);
		wr(wds_pkg::OFF_CTRL, 8'h00);
		$display("test sleep done");
		crystal_clock_mode <= 1'b1;
		wr(wds_pkg::OFF_CTRL, 8'h01);
		k = n_rst;
		pulse_sleep();
		repeat (10) @(posedge clk);
		wake_pending <= 1'b1;
		wait_for(2, 8, n);
		chk("ost request", {7'h00, n <= 8}, 8'h01);
		@(posedge clk);
		wake_pending <= 1'b0;
		wait_for(1, 300, n);
		chk("held until ost", {7'h00, n > 300}, 8'h01);
		chk("no reset in ost", n_rst - k, 8'h00);
		@(posedge clk);
		ost_done <= 1'b1;
		@(posedge clk);
		ost_done <= 1'b0;
		#1 chk("resume after ost", {7'h00, wake_resume}, 8'h01);
		// a count that ran during start-up would expire out of step here
		wait_for(0, 200, n);
		chk("fresh count after ost", inr(n, 32), 8'h01);
		wr(wds_pkg::OFF_CTRL, 8'h00);
		$display("test crystal wake done");
		print_verdict();
	end
endmodule : test_wds_top
